// File: design/current_reference.sv
// Purpose: Register and control logic of the programmable current reference
// Assumes: Special-function register bus synchronous to clk; channel outputs synchronous
// Notes:   Analog controls come straight from register flops; output enable is decoded from a non-zero step count
`timescale 1ns/1ps
`default_nettype none
module current_reference (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic [7:0]         sfrAddr,
	input  wire logic [3:0]         sfrPage,
	input  wire logic               sfrWrite,
	input  wire logic               sfrRead,
	input  wire logic [7:0]         sfrWdata,
	output logic      [7:0]         sfrRdata,
	input  wire logic [5:0]         compareOut,
	output logic                    outputEnable,
	output logic                    sinkMode,
	output logic                    rangeCoarse,
	output logic      [5:0]         stepCount,
	output logic                    trimGate,
	output logic signed [10:0]      currentMicroamps
);
	logic [7:0] ctrlReg;
	logic [7:0] configReg;
	logic       hitCtrl;
	logic       hitConfig;
	logic [7:0] readMux;

	trim_select_if trimBus();

	// Decode: the page tells the two same-address registers apart
	assign hitCtrl   = (sfrAddr == current_ref_pkg::CTRL_ADDR) && (sfrPage == current_ref_pkg::CTRL_PAGE);
	assign hitConfig = (sfrAddr == current_ref_pkg::CONFIG_ADDR) && (sfrPage == current_ref_pkg::CONFIG_PAGE);

	// Control register, all bits writable
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ctrlReg <= current_ref_pkg::CTRL_RESET;
		else if (sfrWrite && hitCtrl)
			ctrlReg <= sfrWdata;
	end

	// Configuration register; unused bits never store, so they always read zero
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			configReg <= current_ref_pkg::CONFIG_RESET;
		else if (sfrWrite && hitConfig)
			configReg <= sfrWdata & current_ref_pkg::CONFIG_WMASK;
	end

	// Read data: unmapped addresses read zero
	assign readMux = hitCtrl   ? ctrlReg :
	                 hitConfig ? configReg : 8'h00;

	// Registered so the bus sees stable data one edge after the strobe
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sfrRdata <= 8'h00;
		else if (sfrRead)
			sfrRdata <= readMux;
	end

	// Controls straight from register flops; enable decoded from a non-zero step count
	assign sinkMode     = ctrlReg[current_ref_pkg::SINK_BIT];
	assign rangeCoarse  = ctrlReg[current_ref_pkg::RANGE_BIT];
	assign stepCount    = ctrlReg[current_ref_pkg::STEP_MSB:current_ref_pkg::STEP_LSB];
	assign outputEnable = (stepCount != 6'h00);

	// Trim path: software is trusted not to write reserved codes, still made safe
	assign trimBus.enable   = configReg[current_ref_pkg::TRIM_EN_BIT];
	assign trimBus.select   = configReg[current_ref_pkg::SEL_MSB:0];
	assign trimBus.channels = compareOut;
	assign trimGate         = trimBus.trimOn;

	trim_select picker (
		.clk   (clk),
		.rst_n (rst_n),
		.sel   (trimBus)
	);

	// Nominal output, for the analog model and for software visibility in test
	assign currentMicroamps = current_ref_pkg::current_of(sinkMode, rangeCoarse, stepCount, trimGate);

	// Assertions
	property p_fine_weight;
		@(posedge clk) disable iff (!rst_n)
		(!rangeCoarse && !sinkMode && !trimGate) |-> (currentMicroamps == $signed({5'h00, stepCount}));
	endproperty
	a_fine_weight: assert property (p_fine_weight) else $error("Fine step weight wrong");

	property p_coarse_weight;
		@(posedge clk) disable iff (!rst_n)
		(rangeCoarse && !sinkMode && !trimGate) |-> (currentMicroamps == $signed({2'h0, stepCount, 3'h0}));
	endproperty
	a_coarse_weight: assert property (p_coarse_weight) else $error("Coarse step weight wrong");

	property p_zero_off;
		@(posedge clk) disable iff (!rst_n)
		(stepCount == 6'h00) |-> (!outputEnable && currentMicroamps == 11'sh000);
	endproperty
	a_zero_off: assert property (p_zero_off) else $error("Zero count left output on");

	property p_write_zero;
		@(posedge clk) disable iff (!rst_n)
		(sfrWrite && hitCtrl && sfrWdata == 8'h00) |=> !outputEnable;
	endproperty
	a_write_zero: assert property (p_write_zero) else $error("Write of zero did not disable");

	property p_sink_sign;
		@(posedge clk) disable iff (!rst_n)
		outputEnable |-> (sinkMode ? currentMicroamps < 0 : currentMicroamps > 0);
	endproperty
	a_sink_sign: assert property (p_sink_sign) else $error("Direction sign wrong");

	property p_trim_equiv;
		@(posedge clk) disable iff (!rst_n)
		(outputEnable && trimGate && stepCount[1:0] == 2'b00) |->
			(currentMicroamps == current_ref_pkg::current_of(sinkMode, rangeCoarse, {stepCount[5:2], 2'b10}, 1'b0));
	endproperty
	a_trim_equiv: assert property (p_trim_equiv) else $error("Trim not worth two LSBs");

	property p_trim_route;
		@(posedge clk) disable iff (!rst_n)
		(trimBus.enable && trimBus.select <= 3'h5) |=> (trimGate == $past(compareOut[trimBus.select]));
	endproperty
	a_trim_route: assert property (p_trim_route) else $error("Trim channel not routed");

	property p_trim_off;
		@(posedge clk) disable iff (!rst_n)
		!trimBus.enable |=> !trimGate;
	endproperty
	a_trim_off: assert property (p_trim_off) else $error("Trim active while disabled");

	property p_unused_zero;
		@(posedge clk) disable iff (!rst_n)
		configReg[6:3] == 4'h0;
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("Unused config bits stored");

	property p_update_next;
		@(posedge clk) disable iff (!rst_n)
		(sfrWrite && hitCtrl) |=> (stepCount == $past(sfrWdata[5:0]) && sinkMode == $past(sfrWdata[7]));
	endproperty
	a_update_next: assert property (p_update_next) else $error("Control change not on next edge");

	property p_reserved_plain;
		@(posedge clk) disable iff (!rst_n)
		(trimBus.select > 3'h5) |=> (currentMicroamps == current_ref_pkg::current_of(sinkMode, rangeCoarse, stepCount, 1'b0));
	endproperty
	a_reserved_plain: assert property (p_reserved_plain) else $error("Reserved code drove trim");

	// Range bit must reach the analog section on the same edge as the step count
	property p_range_follow;
		@(posedge clk) disable iff (!rst_n)
		(sfrWrite && hitCtrl) |=> (rangeCoarse == $past(sfrWdata[6]));
	endproperty
	a_range_follow: assert property (p_range_follow) else $error("Range change not on next edge");

	property p_enable_nonzero;
		@(posedge clk) disable iff (!rst_n)
		(stepCount != 6'h00) |-> outputEnable;
	endproperty
	a_enable_nonzero: assert property (p_enable_nonzero) else $error("Non-zero count left output off");

	property p_sink_magnitude;
		@(posedge clk) disable iff (!rst_n)
		(outputEnable && sinkMode && !rangeCoarse && !trimGate) |-> (currentMicroamps == -$signed({5'h00, stepCount}));
	endproperty
	a_sink_magnitude: assert property (p_sink_magnitude) else $error("Sink magnitude wrong");

	property p_trim_magnitude;
		@(posedge clk) disable iff (!rst_n)
		(outputEnable && trimGate && !sinkMode && !rangeCoarse) |-> (currentMicroamps == $signed({5'h00, stepCount}) + 11'sd2);
	endproperty
	a_trim_magnitude: assert property (p_trim_magnitude) else $error("Trim source not two steps");

	// Only the enable and select bits may ever store
	property p_config_write;
		@(posedge clk) disable iff (!rst_n)
		(sfrWrite && hitConfig) |=> (configReg == {$past(sfrWdata[7]), 4'h0, $past(sfrWdata[2:0])});
	endproperty
	a_config_write: assert property (p_config_write) else $error("Config write stored wrong bits");

	property p_config_keep;
		@(posedge clk) disable iff (!rst_n)
		!(sfrWrite && hitConfig) |=> $stable(configReg);
	endproperty
	a_config_keep: assert property (p_config_keep) else $error("Config changed without a write");

	// Read data is the register as it stood at the strobe edge
	property p_read_ctrl;
		@(posedge clk) disable iff (!rst_n)
		(sfrRead && hitCtrl) |=> (sfrRdata == $past(ctrlReg));
	endproperty
	a_read_ctrl: assert property (p_read_ctrl) else $error("Control read data wrong");

	property p_read_config;
		@(posedge clk) disable iff (!rst_n)
		(sfrRead && hitConfig) |=> (sfrRdata == $past(configReg));
	endproperty
	a_read_config: assert property (p_read_config) else $error("Config read data wrong");

	property p_read_hold;
		@(posedge clk) disable iff (!rst_n)
		!sfrRead |=> $stable(sfrRdata);
	endproperty
	a_read_hold: assert property (p_read_hold) else $error("Read data moved without a strobe");

	// Main scenarios
	c_sink_coarse: cover property (@(posedge clk) disable iff (!rst_n) outputEnable && sinkMode && rangeCoarse);
	c_trim_active: cover property (@(posedge clk) disable iff (!rst_n) outputEnable && trimGate);
	c_disable:     cover property (@(posedge clk) disable iff (!rst_n) outputEnable ##1 !outputEnable);
	c_read_config: cover property (@(posedge clk) disable iff (!rst_n) sfrRead && hitConfig);
	c_reserved_code: cover property (@(posedge clk) disable iff (!rst_n) trimBus.enable && trimBus.select > 3'h5);

endmodule : current_reference
`default_nettype wire

// File: design/current_ref_pkg.sv
// Purpose: Shared constants and helpers for the programmable current reference control
// Assumes: Eight-bit special-function register bus, two pages sharing one address
// Notes:   Magnitude is reported in microamps as a signed two's complement value
`default_nettype none
package current_ref_pkg;

	// Register map: both registers sit at one address, told apart by page
	localparam logic [7:0] CTRL_ADDR   = 8'hb9;
	localparam logic [3:0] CTRL_PAGE   = 4'h0;
	localparam logic [7:0] CONFIG_ADDR = 8'hb9;
	localparam logic [3:0] CONFIG_PAGE = 4'hf;

	// Reset values
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h00;

	// Control register fields
	localparam int SINK_BIT   = 7;
	localparam int RANGE_BIT  = 6;
	localparam int STEP_MSB   = 5;
	localparam int STEP_LSB   = 0;

	// PWM configuration register fields
	localparam int          TRIM_EN_BIT   = 7;
	localparam logic [7:0]  CONFIG_WMASK  = 8'h87;
	localparam int          SEL_MSB       = 2;
	localparam logic [2:0]  SEL_LAST      = 3'h5;
	localparam int          CHANNELS      = 6;

	// Step weights in microamps and the trim source weight in LSBs
	localparam logic [3:0] FINE_WEIGHT   = 4'h1;
	localparam logic [3:0] COARSE_WEIGHT = 4'h8;
	localparam logic [6:0] TRIM_LSBS     = 7'h02;

	// Signed output current in microamps from the live settings
	function automatic logic signed [10:0] current_of(input logic sink, input logic coarse,
		input logic [5:0] steps, input logic trim);
		logic [6:0]  units;
		logic [10:0] mag;
		units = {1'b0, steps} + (trim ? TRIM_LSBS : 7'h00);
		mag   = 11'(units) * 11'(coarse ? COARSE_WEIGHT : FINE_WEIGHT);
		if (steps == 6'h00)
			mag = 11'h000;
		return sink ? -$signed(mag) : $signed(mag);
	endfunction : current_of

endpackage : current_ref_pkg
`default_nettype wire

// File: design/trim_select_if.sv
// Purpose: Carries trim enable, source select and channel outputs to the trim selector
// Assumes: Single clock domain, all signals synchronous
// Notes:   The selector answers with a registered trim level
`timescale 1ns/1ps
`default_nettype none
interface trim_select_if;
	logic       enable;
	logic [2:0] select;
	logic [5:0] channels;
	logic       trimOn;

	modport owner (output enable, output select, output channels, input trimOn);
	modport picker(input enable, input select, input channels, output trimOn);
endinterface : trim_select_if
`default_nettype wire

// File: design/trim_select.sv
// Purpose: Picks one compare/PWM channel as the fine trim gate
// Assumes: Channel outputs are synchronous to clk
// Notes:   Reserved select codes yield a constantly low trim gate
`timescale 1ns/1ps
`default_nettype none
module trim_select (
	input  wire logic      clk,
	input  wire logic      rst_n,
	trim_select_if.picker  sel
);
	logic legalCode;
	logic pickedLevel;

	// Codes past the last channel select nothing
	assign legalCode   = (sel.select <= current_ref_pkg::SEL_LAST);
	assign pickedLevel = legalCode ? sel.channels[sel.select] : 1'b0;

	// Registered so the gate is glitch free toward the analog source
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sel.trimOn <= 1'b0;
		else
			sel.trimOn <= sel.enable && pickedLevel;
	end

	property p_reserved_low;
		@(posedge clk) disable iff (!rst_n)
		(sel.select > current_ref_pkg::SEL_LAST) |=> !sel.trimOn;
	endproperty
	a_reserved_low: assert property (p_reserved_low) else $error("Reserved select gave trim");

endmodule : trim_select
`default_nettype wire

// File: dv/pwm_channel_model.sv
// Purpose: Stands in for the six compare/PWM channel outputs of the counter array
// Assumes: Channels change only on the system clock
// Notes:   Levels are registered, so the model is never faster than real counter logic
`timescale 1ns/1ps
`default_nettype none
module pwm_channel_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [5:0] levels,
	output logic      [5:0] chanOut
);
	// Channels idle low in reset, as a stopped counter array would
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			chanOut <= 6'h00;
		else
			chanOut <= levels;
endmodule : pwm_channel_model
`default_nettype wire

// File: dv/current_reference_tb.sv
// Purpose: Self-checking bench for the current reference control block
// Assumes: One register access per strobe, results visible after the next edge
// Notes:   Trim checks allow one cycle in the channel model and one in the selector
`timescale 1ns/1ps
`default_nettype none
module current_reference_tb;
	logic               clk      = 1'b0;
	logic               rst_n    = 1'b0;
	logic [7:0]         sfrAddr  = current_ref_pkg::CTRL_ADDR;
	logic [3:0]         sfrPage  = 4'h0;
	logic               sfrWrite = 1'b0;
	logic               sfrRead  = 1'b0;
	logic [7:0]         sfrWdata = 8'h00;
	logic [5:0]         levels   = 6'h00;
	logic [7:0]         sfrRdata;
	logic [5:0]         compareOut;
	logic               outputEnable;
	logic               sinkMode;
	logic               rangeCoarse;
	logic               trimGate;
	logic [5:0]         stepCount;
	logic signed [10:0] currentMicroamps;
	logic [7:0]         rd;
	int                 fail_count = 0;
	int                 num_checks = 0;

	// Half period of 25 ns gives 20 MHz
	always #25 clk = ~clk;

	pwm_channel_model far (.clk(clk), .rst_n(rst_n), .levels(levels), .chanOut(compareOut));

	current_reference dut (.clk(clk), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrPage(sfrPage),
		.sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
		.compareOut(compareOut), .outputEnable(outputEnable), .sinkMode(sinkMode), .rangeCoarse(rangeCoarse),
		.stepCount(stepCount), .trimGate(trimGate), .currentMicroamps(currentMicroamps));

	// Case equality so an unknown never passes
	task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// One-cycle strobe; read data and new controls both land on the following edge
	task automatic access(input logic wr, input logic [3:0] page, input logic [7:0] data);
		@(posedge clk);
		sfrPage  <= page;
		sfrWdata <= data;
		sfrWrite <= wr;
		sfrRead  <= !wr;
		@(posedge clk);
		sfrWrite <= 1'b0;
		sfrRead  <= 1'b0;
		#1 rd = sfrRdata;
	endtask : access

	// Channel levels take two edges to reach the output; the task waits three
	task automatic drive(input logic [5:0] v);
		@(posedge clk);
		levels <= v;
		repeat (3) @(posedge clk);
		#1;
	endtask : drive

	task automatic t_reset;
		access(1'b0, current_ref_pkg::CTRL_PAGE, 8'h00);
		chk("ctrl reset", 11'(rd), 11'h000);
		access(1'b0, current_ref_pkg::CONFIG_PAGE, 8'h00);
		chk("config reset", 11'(rd), 11'h000);
		chk("enable reset", 11'(outputEnable), 11'h000);
	endtask : t_reset

	task automatic t_ctrl;
		logic [7:0]  v [4] = '{8'h85, 8'h7f, 8'hc1, 8'h00};
		logic [10:0] e [4] = '{-11'sd5, 11'd504, -11'sd8, 11'd0};
		for (int i = 0; i < 4; i++)
		begin
			access(1'b1, current_ref_pkg::CTRL_PAGE, v[i]);
			chk("current", currentMicroamps, e[i]);
			chk("enable", 11'(outputEnable), 11'(v[i][5:0] != 6'h00));
			chk("range", 11'(rangeCoarse), 11'(v[i][6]));
			chk("sink", 11'(sinkMode), 11'(v[i][7]));
			chk("steps", 11'(stepCount), 11'(v[i][5:0]));
			access(1'b0, current_ref_pkg::CTRL_PAGE, 8'h00);
			chk("ctrl read", 11'(rd), 11'(v[i]));
		end
	endtask : t_ctrl

	// Reserved select codes must leave the gate low even with every channel high
	task automatic t_config;
		access(1'b1, current_ref_pkg::CONFIG_PAGE, 8'hff);
		access(1'b0, current_ref_pkg::CONFIG_PAGE, 8'h00);
		chk("config read", 11'(rd), 11'h087);
		access(1'b1, current_ref_pkg::CTRL_PAGE, 8'h03);
		for (int c = 6; c < 8; c++)
		begin
			access(1'b1, current_ref_pkg::CONFIG_PAGE, 8'h80 | 8'(c));
			drive(6'h3f);
			chk("reserved gate", 11'(trimGate), 11'h000);
			chk("reserved current", currentMicroamps, 11'd3);
		end
	endtask : t_config

	task automatic t_select;
		access(1'b1, current_ref_pkg::CTRL_PAGE, 8'h44);
		for (int i = 0; i < 6; i++)
		begin
			access(1'b1, current_ref_pkg::CONFIG_PAGE, 8'h80 | 8'(i));
			drive(6'h01 << i);
			chk("gate high", 11'(trimGate), 11'h001);
			chk("trim current", currentMicroamps, 11'd48);
			drive(~(6'h01 << i));
			chk("gate low", 11'(trimGate), 11'h000);
			chk("untrimmed", currentMicroamps, 11'd32);
		end
		access(1'b1, current_ref_pkg::CONFIG_PAGE, 8'h05);
		drive(6'h3f);
		chk("trim off", currentMicroamps, 11'd32);
	endtask : t_select

	// A foreign page neither writes nor reads back anything
	task automatic t_unmapped;
		access(1'b1, 4'h1, 8'hff);
		chk("unmapped write", 11'(stepCount), 11'h004);
		access(1'b0, 4'h1, 8'h00);
		chk("unmapped read", 11'(rd), 11'h000);
		// Right page but a foreign address must not reach the control register either
		@(posedge clk);
		sfrAddr <= 8'hba;
		access(1'b1, current_ref_pkg::CTRL_PAGE, 8'hff);
		chk("foreign addr write", 11'(stepCount), 11'h004);
		access(1'b0, current_ref_pkg::CTRL_PAGE, 8'h00);
		chk("foreign addr read", 11'(rd), 11'h000);
		@(posedge clk);
		sfrAddr <= current_ref_pkg::CTRL_ADDR;
		access(1'b0, current_ref_pkg::CTRL_PAGE, 8'h00);
		chk("ctrl kept", 11'(rd), 11'h044);
	endtask : t_unmapped

	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results

	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_ctrl();
		t_config();
		t_select();
		t_unmapped();
		results();
	end

	// The run needs some 130 cycles; over fifteen times that means a hang
	initial
	begin
		repeat (2000) @(posedge clk);
		fail_count++;
		results();
	end
endmodule : current_reference_tb
`default_nettype wire
